// file: scir_host.sv
`timescale 1ns/1ps
// strobes stand for exactly one edge; released lines show inverted values
module scir_host (
   input wire logic mclk_i,
   output logic wr_i, rd_i,
   output logic [11:0] addr_i,
   output logic [7:0] wdata_i);
   initial {wr_i, rd_i, addr_i, wdata_i} = 22'h000000;
   task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      #1 {wr_i, rd_i, addr_i, wdata_i} = {w, !w, a, d};
      @(posedge mclk_i);
      #1 {wr_i, rd_i, addr_i, wdata_i} = {2'b00, ~a, ~d};
   endtask : acc
endmodule : scir_host

// file: scir_id_if.sv
`timescale 1ns/1ps
interface scir_id_if;
   logic [11:0] addr;
   logic [7:0] data;
   logic hit;
   modport rom (input addr, output data, output hit);
   modport user (output addr, input data, input hit);
endinterface : scir_id_if

// file: scir_id_rom.sv
`timescale 1ns/1ps
// fixed identification bytes; no write path exists at all
module scir_id_rom #(
   parameter logic [7:0] PART_TYPE = 8'hA1,
   parameter logic [15:0] PRODUCT = 16'hB2C3,
   parameter logic [7:0] SIL_REV = 8'hD4,
   parameter logic [15:0] MAKER = 16'hE5F6
) (
   scir_id_if.rom id
);
   always_comb begin
      id.hit = 1'b1;
      case (id.addr)
         scir_pkg::OFS_PART_TYPE: id.data = PART_TYPE;
         scir_pkg::OFS_PROD_HI: id.data = PRODUCT[15:8];
         scir_pkg::OFS_PROD_LO: id.data = PRODUCT[7:0];
         scir_pkg::OFS_SIL_REV: id.data = SIL_REV;
         scir_pkg::OFS_MAKER_HI: id.data = MAKER[15:8];
         scir_pkg::OFS_MAKER_LO: id.data = MAKER[7:0];
         default: begin
            id.data = scir_pkg::READ_ZERO;
            id.hit = 1'b0;
         end
      endcase
   end
endmodule : scir_id_rom

// file: scir_pkg.sv
package scir_pkg;
   localparam logic [11:0] OFS_RESET_WIRE = 12'h000;
   localparam logic [11:0] OFS_SLEEP = 12'h002;
   localparam logic [11:0] OFS_PART_TYPE = 12'h003;
   localparam logic [11:0] OFS_PROD_HI = 12'h004;
   localparam logic [11:0] OFS_PROD_LO = 12'h005;
   localparam logic [11:0] OFS_SIL_REV = 12'h006;
   localparam logic [11:0] OFS_MAKER_HI = 12'h00C;
   localparam logic [11:0] OFS_MAKER_LO = 12'h00D;
   localparam int BIT_SOFT_RESET = 7;
   localparam int BIT_THREE_WIRE_DIS = 4;
   localparam int BIT_SLEEP = 0;
   localparam logic RST_THREE_WIRE_DIS = 1'b0;
   localparam logic RST_SLEEP = 1'b0;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam int EVEN_IDX_MAX = 12;
   localparam int ODD_IDX_MAX = 13;
   // pin-function selector code meaning serial readback; value arbitrary
   localparam logic [2:0] PINFN_READBACK = 3'h6;
endpackage : scir_pkg

// file: scir_regs.sv
`timescale 1ns/1ps
module scir_regs #(
   parameter logic [7:0] PART_TYPE = 8'hA1, // arbitrary
   parameter logic [15:0] PRODUCT = 16'hB2C3, // arbitrary
   parameter logic [7:0] SIL_REV = 8'hD4, // arbitrary
   parameter logic [15:0] MAKER = 16'hE5F6 // arbitrary
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // register access from the serial interface
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [11:0] addr_i,
   input wire logic [7:0] wdata_i,
   // pin-function selector held elsewhere in the map
   input wire logic [2:0] input_select0_pin_function_i,
   // results
   output logic [7:0] rdata_o,
   output logic rvalid_o,
   output logic soft_reset_o,
   output logic three_wire_en_o,
   output logic four_wire_en_o,
   output logic sleep_request_o
);
   typedef struct packed {
      logic soft_reset;
      logic three_wire_disable;
      logic three_wire_en;
      logic sleep_request;
      logic four_wire;
      logic [7:0] rdata;
      logic rvalid;
   } scir_state_t;

   scir_state_t state_reg;
   scir_state_t state_next;
   scir_id_if id_bus();

   scir_id_rom #(
      .PART_TYPE(PART_TYPE),
      .PRODUCT(PRODUCT),
      .SIL_REV(SIL_REV),
      .MAKER(MAKER)
   ) u_id (
      .id(id_bus)
   );

   assign id_bus.addr = addr_i;

   always_comb begin
      state_next = state_reg;
      state_next.soft_reset = 1'b0;
      state_next.rvalid = rd_i;
      if (wr_i) begin
         case (addr_i)
            scir_pkg::OFS_RESET_WIRE: begin
               state_next.soft_reset = wdata_i[scir_pkg::BIT_SOFT_RESET];
               state_next.three_wire_disable = wdata_i[scir_pkg::BIT_THREE_WIRE_DIS];
            end
            scir_pkg::OFS_SLEEP: state_next.sleep_request = wdata_i[scir_pkg::BIT_SLEEP];
            default: ; // id bytes and unmapped addresses drop writes
         endcase
      end
      // kept as its own flop so the pin comes straight from a register
      state_next.three_wire_en = ~state_next.three_wire_disable;
      // no per-output fields here, so even and odd index bounds stay unused
      // four-wire output follows the readback selector alone; three-wire enable is not masked by it
      state_next.four_wire = (input_select0_pin_function_i == scir_pkg::PINFN_READBACK);
      if (rd_i) begin
         case (addr_i)
            scir_pkg::OFS_RESET_WIRE: begin
               state_next.rdata = scir_pkg::READ_ZERO;
               state_next.rdata[scir_pkg::BIT_THREE_WIRE_DIS] = state_reg.three_wire_disable;
            end
            scir_pkg::OFS_SLEEP: begin
               state_next.rdata = scir_pkg::READ_ZERO;
               state_next.rdata[scir_pkg::BIT_SLEEP] = state_reg.sleep_request;
            end
            default: state_next.rdata = id_bus.data;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         state_reg <= '0;
         state_reg.three_wire_disable <= scir_pkg::RST_THREE_WIRE_DIS;
         state_reg.three_wire_en <= ~scir_pkg::RST_THREE_WIRE_DIS;
         state_reg.sleep_request <= scir_pkg::RST_SLEEP;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_o = state_reg.rdata;
   assign rvalid_o = state_reg.rvalid;
   assign soft_reset_o = state_reg.soft_reset;
   assign three_wire_en_o = state_reg.three_wire_en;
   assign four_wire_en_o = state_reg.four_wire;
   assign sleep_request_o = state_reg.sleep_request;
endmodule : scir_regs

// file: scir_regs_monitor.sv
`timescale 1ns/1ps
module scir_mon #(parameter logic [7:0] PART_TYPE = 8'hA1) (
   input wire logic mclk_i, rst_i, wr_i, rd_i, rvalid_o, soft_reset_o, three_wire_en_o, four_wire_en_o, sleep_request_o,
   input wire logic [11:0] addr_i,
   input wire logic [7:0] wdata_i, rdata_o,
   input wire logic [2:0] input_select0_pin_function_i);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   soft_pulse_a: assert property (wr_i && addr_i == 12'h000 && wdata_i[7] |=> soft_reset_o) else $error("bad");
   soft_clear_a: assert property (soft_reset_o |=> !soft_reset_o) else $error("bad");
   wire_mode_a: assert property (wr_i && addr_i == 12'h000 |=> three_wire_en_o != $past(wdata_i[4])) else $error("bad");
   four_wire_a: assert property (!rst_i |=> four_wire_en_o == ($past(input_select0_pin_function_i) == 3'h6))
      else $error("bad");
   sleep_bit_a: assert property (wr_i && addr_i == 12'h002 |=> sleep_request_o == $past(wdata_i[0])) else $error("bad");
   read_valid_a: assert property (!rst_i |=> rvalid_o == $past(rd_i)) else $error("bad");
   part_type_a: assert property (rd_i && addr_i == 12'h003 |=> rdata_o == PART_TYPE) else $error("bad");
   reserved_zero_a: assert property (rd_i && addr_i == 12'h000 |=> rdata_o[7:5] == 3'h0) else $error("bad");
   cover property (soft_reset_o);
   cover property (four_wire_en_o);
   cover property (rvalid_o && rdata_o == PART_TYPE);
endmodule : scir_mon
bind scir_regs scir_mon #(.PART_TYPE(PART_TYPE)) u_mon (.*);

// file: system_control_id_regs_tb.sv
`timescale 1ns/1ps
module system_control_id_regs_tb;
   logic mclk_i = 1'b0, rst_i = 1'b1, wr_i, rd_i, rvalid_o, soft_o, tw_o, fw_o, sl_o, m4 = 1'b0, m0 = 1'b0;
   logic [11:0] addr_i;
   logic [7:0] wdata_i, rdata_o, d, e;
   logic [2:0] sel = 3'h0;
   int miscompares = 0, compares = 0, i;
   logic [11:0] tbl [10] = '{12'h000, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006, 12'h00C, 12'h00D, 12'h001, 12'h007};
   logic [7:0] idv [6] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'hE5, 8'hF6};
   scir_host u_host (.mclk_i(mclk_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i));
   scir_regs u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .input_select0_pin_function_i(sel), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .soft_reset_o(soft_o),
      .three_wire_en_o(tw_o), .four_wire_en_o(fw_o), .sleep_request_o(sl_o));
   initial forever #2 mclk_i = ~mclk_i;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   initial begin
      #5000 miscompares++;
      complete_run();
   end
   initial begin
      void'($urandom(85));
      repeat (16) @(posedge mclk_i);
      #1 rst_i = 1'b0;
      chk({5'h00, soft_o, tw_o, sl_o}, 8'h02);
      for (int k = 0; k < 60; k++) begin
         i = int'($urandom % 10);
         d = 8'($urandom);
         sel = 3'($urandom);
         u_host.acc(1'b1, tbl[i], d);
         if (i == 0) m4 = d[4];
         if (i == 1) m0 = d[0];
         chk({4'h0, soft_o, tw_o, sl_o, fw_o}, {4'h0, i == 0 && d[7], !m4, m0, sel == 3'h6});
         u_host.acc(1'b0, tbl[i], 8'h00);
         e = (i == 0) ? {3'h0, m4, 4'h0} : (i == 1) ? {7'h00, m0} : (i < 8) ? idv[i-2] : 8'h00;
         chk(rdata_o, e);
         chk({7'h00, rvalid_o}, 8'h01);
      end
      complete_run();
   end
endmodule : system_control_id_regs_tb
